// *** inc/asr_pkg.sv ***
// How it works
// - Four link pins: start/select in, serial in, serial out, serial clock in.
// - The start/select line is both chip select and conversion trigger.
// - A rising edge of start/select while idle begins a new conversion.
// - A started conversion always finishes, whatever start/select does meanwhile.
// - After conversion, start/select low puts the result on the serial output.
// - Result leaves MSB first, changing on each serial clock falling edge.
// - Output floats after the last bit or when start/select rises, earliest.
// - 1024 serial clocks during standby, data clocks included, start recalibration.
// - Output driven low during recalibration, floated again when it finishes.
// - Recalibration lasts about 500 ms until the output is released.
// - The result MSB is always a sign bit.
// - Differential codes are two's complement, saturating at both full scales.
package asr_pkg;

    localparam int DATA_W        = 16;
    localparam int RAW_W         = 18;
    localparam int CNT_W         = 16;
    localparam int FIFO_DEPTH    = 8;
    localparam int CLK_PERIOD_NS = 50;
    localparam int CONV_TIME_NS  = 1000;
    localparam int CAL_TIME_MS   = 500;
    // Least time: round up
    localparam int CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Approximate time: round down
    localparam int CAL_CYCLES    = (CAL_TIME_MS * 1_000_000) / CLK_PERIOD_NS;

    localparam logic [CNT_W-1:0]  RECAL_PULSES = 16'h0400;
    localparam logic [DATA_W-1:0] CODE_POS_FS  = 16'h7fff;
    localparam logic [DATA_W-1:0] CODE_NEG_FS  = 16'h8000;
    localparam logic [DATA_W-1:0] CODE_RESET   = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_CAL  = 3'b100
    } asr_state_t;

    // Raw signed converter value, wider than the code so saturation can be seen
    typedef struct packed {
        logic signed [RAW_W-1:0] raw;
    } asr_sample_t;

endpackage

// *** hw/asr_readout.sv ***
module asr_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_resetn,
    // Fill side
    input  wire logic             i_valid,
    output logic                  o_ready,
    input  wire logic [WIDTH-1:0] i_data,
    // Drain side
    output logic                  o_valid,
    input  wire logic             i_ready,
    output logic [WIDTH-1:0]      o_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             full;
    logic             empty;
    logic             push;
    logic             pop;

    assign empty   = (wr_ptr == rd_ptr);
    assign full    = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
    assign o_ready = ~full;
    assign o_valid = ~empty;
    assign push    = i_valid & ~full;
    assign pop     = i_ready & ~empty;
    assign o_data  = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= i_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            wr_ptr <= '0;
        end else if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            rd_ptr <= '0;
        end else if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule // asr_fifo

module asr_readout #(
    parameter int DATA_W     = asr_pkg::DATA_W,
    parameter int FIFO_DEPTH = asr_pkg::FIFO_DEPTH,
    parameter int CAL_CYCLES = asr_pkg::CAL_CYCLES
) (
    // Core clock and reset, then the serial link pins
    input  wire logic                 i_clk,
    input  wire logic                 i_resetn,
    input  wire logic                 i_sclk,
    input  wire logic                 i_conv_start_select,
    input  wire logic                 i_serial_in_line,
    output logic                      o_serial_out_line,
    output logic                      o_serial_out_oe,
    // Sample stream from the converter core
    input  wire logic                 i_sample_valid,
    input  wire asr_pkg::asr_sample_t i_sample,
    output logic                      o_sample_ready,
    // Status
    output logic                      o_busy,
    output logic                      o_calibrating,
    output logic [DATA_W-1:0]         o_result
);
    localparam int CNT_W = asr_pkg::CNT_W;
    localparam int RAW_W = asr_pkg::RAW_W;
    localparam int IDX_W = $clog2(DATA_W) + 1;
    localparam logic [31:0] CONV_LAST = 32'(asr_pkg::CONV_CYCLES - 1);
    localparam logic [31:0] CAL_LAST  = 32'(CAL_CYCLES - 1);
    localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(DATA_W);

    // Core domain
    asr_pkg::asr_state_t state;
    logic [31:0]         timer;
    logic                cs_meta;
    logic                cs_sync;
    logic                cs_prev;
    logic                cs_rise;
    logic                result_ready;
    logic [CNT_W-1:0]    gray_meta;
    logic [CNT_W-1:0]    gray_sync;
    logic [CNT_W-1:0]    pulse_cnt;
    logic [CNT_W-1:0]    pulse_base;
    logic [CNT_W-1:0]    pulses;
    logic                recal_hit;
    logic                conv_done;
    logic                fifo_valid;
    asr_pkg::asr_sample_t fifo_data;
    logic [DATA_W-1:0]   next_code;

    // Link domain, reset flops and counters initialised because the link clock may not run during reset; bit_idx is cleared by a high select
    logic                rst_meta   = 1'b1;
    logic                rst_link   = 1'b1;
    logic [CNT_W-1:0]    fall_cnt   = '0;
    logic [CNT_W-1:0]    fall_gray  = '0;
    logic [IDX_W-1:0]    bit_idx;

    // Serial input is held high by the host and carries nothing here
    logic                sdi_unused;
    assign sdi_unused = i_serial_in_line;

    asr_fifo #(
        .WIDTH (RAW_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_valid  (i_sample_valid),
        .o_ready  (o_sample_ready),
        .i_data   (i_sample.raw),
        .o_valid  (fifo_valid),
        .i_ready  (conv_done),
        .o_data   (fifo_data.raw)
    );

    function automatic logic [CNT_W-1:0] gray_to_bin(input logic [CNT_W-1:0] g);
        logic [CNT_W-1:0] b;
        b = '0;
        b[CNT_W-1] = g[CNT_W-1];
        for (int i = CNT_W - 2; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // Start/select crosses into the core clock
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            cs_prev <= 1'b1;
        end else begin
            cs_meta <= i_conv_start_select;
            cs_sync <= cs_meta;
            cs_prev <= cs_sync;
        end
    end

    assign cs_rise = cs_sync & ~cs_prev;

    // Serial clock count crosses as gray code
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            gray_meta <= '0;
            gray_sync <= '0;
        end else begin
            gray_meta <= fall_gray;
            gray_sync <= gray_meta;
        end
    end

    assign pulse_cnt = gray_to_bin(gray_sync);
    assign pulses    = pulse_cnt - pulse_base;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            pulse_base <= pulse_cnt;
        end else if (state != asr_pkg::ST_IDLE || cs_rise) begin
            pulse_base <= pulse_cnt;
        end
    end

    assign recal_hit = (state == asr_pkg::ST_IDLE) && !cs_rise && (pulses >= asr_pkg::RECAL_PULSES);

    assign conv_done = (state == asr_pkg::ST_CONV) && (timer == '0);

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            state <= asr_pkg::ST_IDLE;
            timer <= '0;
        end else begin
            unique case (state)
                asr_pkg::ST_IDLE: begin
                    if (cs_rise) begin
                        state <= asr_pkg::ST_CONV;
                        timer <= CONV_LAST;
                    end else if (recal_hit) begin
                        state <= asr_pkg::ST_CAL;
                        timer <= CAL_LAST;
                    end
                end
                asr_pkg::ST_CONV: begin
                    if (timer == '0) begin
                        state <= asr_pkg::ST_IDLE;
                    end else begin
                        timer <= timer - 1'b1;
                    end
                end
                asr_pkg::ST_CAL: begin
                    if (timer == '0) begin
                        state <= asr_pkg::ST_IDLE;
                    end else begin
                        timer <= timer - 1'b1;
                    end
                end
                default: begin
                    state <= asr_pkg::ST_IDLE;
                    timer <= '0;
                end
            endcase
        end
    end

    always_comb begin
        if (fifo_data.raw > $signed({{(RAW_W-DATA_W){1'b0}}, asr_pkg::CODE_POS_FS})) begin
            next_code = asr_pkg::CODE_POS_FS;
        end else if (fifo_data.raw < $signed({{(RAW_W-DATA_W){1'b1}}, asr_pkg::CODE_NEG_FS})) begin
            next_code = asr_pkg::CODE_NEG_FS;
        end else begin
            next_code = fifo_data.raw[DATA_W-1:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_result <= asr_pkg::CODE_RESET;
        end else if (conv_done && fifo_valid) begin
            o_result <= next_code;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            result_ready <= 1'b0;
        end else if (conv_done) begin
            result_ready <= 1'b1;
        end else if (cs_rise) begin
            result_ready <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_busy        <= 1'b0;
            o_calibrating <= 1'b0;
        end else begin
            o_busy        <= (state == asr_pkg::ST_CONV);
            o_calibrating <= (state == asr_pkg::ST_CAL);
        end
    end

    // Reset reaches the link domain on a level crossing
    always_ff @(negedge i_sclk) begin
        rst_meta <= ~i_resetn;
        rst_link <= rst_meta;
    end

    // every falling edge counts, data clocks included
    always_ff @(negedge i_sclk) begin
        if (rst_link) begin
            fall_cnt  <= '0;
            fall_gray <= '0;
        end else begin
            fall_cnt  <= fall_cnt + 1'b1;
            fall_gray <= (fall_cnt + 1'b1) ^ ((fall_cnt + 1'b1) >> 1);
        end
    end

    // next bit on each falling edge; a high select ends the frame
    always_ff @(negedge i_sclk or posedge i_conv_start_select) begin
        if (i_conv_start_select) begin
            bit_idx <= '0;
        end else if (bit_idx != LAST_IDX) begin
            bit_idx <= bit_idx + 1'b1;
        end
    end

    // drive low while calibrating, float after last bit or select high
    always_comb begin
        if (state == asr_pkg::ST_CAL) begin
            o_serial_out_oe   = 1'b1;
            o_serial_out_line = 1'b0;
        end else if (!i_conv_start_select && result_ready && state == asr_pkg::ST_IDLE
                     && bit_idx != LAST_IDX) begin
            o_serial_out_oe   = 1'b1;
            o_serial_out_line = o_result[DATA_W - 1 - 32'(bit_idx)];
        end else begin
            o_serial_out_oe   = 1'b0;
            o_serial_out_line = 1'b0;
        end
    end
endmodule // asr_readout

// *** dv/asr_chk.sv ***
module asr_chk #(
    parameter int CAL_CYCLES = 200
) (
    // Core clock and reset
    input  wire logic                        i_clk,
    input  wire logic                        i_resetn,
    // Watched ports
    input  wire logic                        i_conv_start_select,
    input  wire logic                        i_sample_valid,
    input  wire logic                        o_serial_out_line,
    input  wire logic                        o_serial_out_oe,
    input  wire logic                        o_sample_ready,
    input  wire logic                        o_busy,
    input  wire logic                        o_calibrating,
    input  wire logic [asr_pkg::DATA_W-1:0]  o_result
);
    int cal_cnt;
    // Calibration length, too long to unroll as a repetition
    always_ff @(posedge i_clk) begin
        if (!i_resetn || !o_calibrating) cal_cnt <= 0;
        else cal_cnt <= cal_cnt + 1;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    // Busy stands for the twenty cycles of one conversion
    sequence conv_run;
        o_busy [*8] ##1 o_busy [*8] ##1 o_busy [*4];
    endsequence
    sequence cal_hold;
        (o_serial_out_oe && !o_serial_out_line) [*8];
    endsequence
    start_to_busy_a: assert property ($rose(i_conv_start_select) && !o_busy && !o_calibrating |-> ##[1:6] o_busy)
        else $error("start edge did not begin a conversion");
    conv_length_a: assert property ($rose(o_busy) |-> conv_run ##1 !o_busy)
        else $error("conversion length wrong");
    busy_no_drive_a: assert property (o_busy |-> !o_serial_out_oe)
        else $error("output driven during conversion");
    result_at_end_a: assert property ($changed(o_result) |-> o_busy)
        else $error("result changed outside conversion end");
    pin_high_float_a: assert property (i_conv_start_select && o_serial_out_oe |-> !o_serial_out_line)
        else $error("output driven with data while pin high");
    cal_drive_low_a: assert property ($rose(o_calibrating) |-> cal_hold)
        else $error("output not held low in calibration");
    cal_length_a: assert property ($fell(o_calibrating) |-> cal_cnt >= CAL_CYCLES - 2 && cal_cnt <= CAL_CYCLES + 2)
        else $error("calibration length wrong");
    cal_release_a: assert property ($fell(o_calibrating) && i_conv_start_select |-> !o_serial_out_oe)
        else $error("output not released after calibration");
    busy_cal_excl_a: assert property (!(o_busy && o_calibrating))
        else $error("conversion and calibration overlap");
    ready_fall_a: assert property ($fell(o_sample_ready) |-> $past(i_sample_valid))
        else $error("buffer full without a push");
endmodule // asr_chk

bind asr_readout asr_chk #(.CAL_CYCLES(CAL_CYCLES)) chk (
    .i_clk               (i_clk),
    .i_resetn            (i_resetn),
    .i_conv_start_select (i_conv_start_select),
    .i_sample_valid      (i_sample_valid),
    .o_serial_out_line   (o_serial_out_line),
    .o_serial_out_oe     (o_serial_out_oe),
    .o_sample_ready      (o_sample_ready),
    .o_busy              (o_busy),
    .o_calibrating       (o_calibrating),
    .o_result            (o_result)
);

// *** dv/asr_host.sv ***
module asr_host (
    // Link pins
    output logic        o_sclk,
    output logic        o_css,
    output logic        o_sdi,
    input  wire logic   i_sdo,
    // Captured word
    output logic [15:0] o_word,
    output logic        o_done
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_sclk = 0;
        o_css = 1;
        o_sdi = 1;
        o_word = 16'h0000;
        o_done = 0;
    end
    task automatic set_pin(input logic v);
        o_css = v;
    endtask
    // bare clocks, recal only on request
    task automatic pulses(input int n);
        #7;
        repeat (n) begin
            o_sclk = 1;
            #24;
            o_sclk = 0;
            #24;
        end
    endtask
    // capture before the falling edge moves the bit
    task automatic frame(input int n);
        o_word = 16'h0000;
        #7;
        repeat (n) begin
            o_sclk = 1;
            #24;
            o_word = {o_word[14:0], i_sdo};
            o_sclk = 0;
            #24;
        end
        o_done = 1;
        #1 o_done = 0;
    endtask
    // poll the pulled-up line before converting again
    task automatic wait_high(output int t);
        t = 0;
        while (i_sdo !== 1'b1 && t < 1000) begin
            #50;
            t++;
        end
    endtask
endmodule // asr_host

// *** dv/adc_serial_readout_recal_bench.sv ***
module adc_serial_readout_recal_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CAL = 200;
    logic                 i_clk = 0;
    logic                 i_resetn = 0;
    logic                 i_sample_valid = 0;
    asr_pkg::asr_sample_t i_sample = '0;
    logic                 sclk, css, serial_in_line, line, oe, sready, busy, cal, word_done;
    logic [15:0]          result, word;
    logic [15:0]          codes[8];
    logic [15:0]          exp_q[$];
    logic [17:0]          fixed[4] = '{18'h1_0000, 18'h2_0000, 18'h0_7fff, 18'h3_8000};
    int                   fail_count = 0, checked = 0, cycles = 0;
    // Pull-up on the serial output
    wire                  sdo_wire = oe ? line : 1'b1;
    always #25 i_clk = ~i_clk;
    asr_host host (.o_sclk(sclk), .o_css(css), .o_sdi(serial_in_line), .i_sdo(sdo_wire), .o_word(word), .o_done(word_done));
    asr_readout #(.CAL_CYCLES(CAL)) DUT (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_sclk(sclk), .i_conv_start_select(css),
        .i_serial_in_line(serial_in_line), .o_serial_out_line(line), .o_serial_out_oe(oe),
        .i_sample_valid(i_sample_valid), .i_sample(i_sample), .o_sample_ready(sready),
        .o_busy(busy), .o_calibrating(cal), .o_result(result)
    );
    task automatic check(input logic [15:0] seen, input logic [15:0] expv);
        checked++;
        if (seen !== expv) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask
    task automatic close_out();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wait_flag(ref logic f, input logic v);
        int n;
        n = 0;
        while (f !== v && n < 2000) begin
            @(negedge i_clk);
            n++;
        end
        // A flag that never arrives is a failure, not a pass
        if (f !== v) fail_count++;
    endtask
    function automatic logic [15:0] sat(input logic signed [17:0] r);
        if (r > 32767) return 16'h7fff;
        if (r < -32768) return 16'h8000;
        return r[15:0];
    endfunction
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 10000) begin
            fail_count++;
            close_out();
        end
    end
    // Frames are judged against the oldest expectation
    always @(posedge word_done) begin
        if (exp_q.size() > 0) check(word, exp_q.pop_front());
        else fail_count++;
    end
    initial begin
        int k;
        int t;
        void'($urandom(19));
        fork
            repeat (12) @(posedge i_clk);
            host.pulses(2);
        join
        @(negedge i_clk) i_resetn = 1;
        @(negedge i_clk);
        check(result, 16'h0000);
        check({15'h0000, sready}, 16'h0001);
        for (k = 0; k < 8; k++) begin
            i_sample_valid = 1;
            i_sample.raw = (k < 4) ? fixed[k] : 18'($urandom);
            codes[k] = sat(i_sample.raw);
            @(negedge i_clk);
        end
        // Ninth word must be refused by the full buffer
        check({15'h0000, sready}, 16'h0000);
        i_sample.raw = 18'h0_0001;
        @(negedge i_clk) i_sample_valid = 0;
        host.set_pin(0);
        repeat (4) @(negedge i_clk);
        // No result yet, so a low pin must not drive
        check({15'h0000, oe}, 16'h0000);
        for (k = 0; k < 9; k++) begin
            host.set_pin(1);
            #1 check({15'h0000, oe}, 16'h0000);
            wait_flag(busy, 1);
            if (k == 1) begin
                host.set_pin(0);
                repeat (3) @(negedge i_clk);
                host.set_pin(1);
            end
            wait_flag(busy, 0);
            @(negedge i_clk);
            check(result, codes[k < 8 ? k : 7]);
            host.set_pin(0);
            exp_q.push_back(k == 3 ? {8'h00, codes[3][15:8]} : codes[k < 8 ? k : 7]);
            host.frame(k == 3 ? 8 : 16);
            // Unipolar reading: sign dropped, rest is plain binary
            if (k == 2) check({1'b0, word[14:0]}, 16'h7fff);
            @(negedge i_clk);
            check({15'h0000, oe}, {15'h0000, k == 3});
        end
        host.set_pin(1);
        wait_flag(busy, 1);
        wait_flag(busy, 0);
        host.pulses(1023);
        repeat (10) @(negedge i_clk);
        check({15'h0000, cal}, 16'h0000);
        host.pulses(1);
        wait_flag(cal, 1);
        check({14'h0000, oe, sdo_wire}, 16'h0002);
        host.wait_high(t);
        check({15'h0000, t >= CAL - 5 && t <= CAL + 5}, 16'h0001);
        repeat (4) @(negedge i_clk);
        check({15'h0000, sdo_wire}, 16'h0001);
        close_out();
    end
endmodule // adc_serial_readout_recal_bench
